// ---- acc_pkg.sv ----
// Package for the converter control block: offsets, field positions, reset values and counts
package acc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] ACC_OFS_CTL0     = 6'h00;
  localparam logic [5:0] ACC_OFS_CTL1     = 6'h01;
  localparam logic [5:0] ACC_OFS_DATA_HI  = 6'h02;
  localparam logic [5:0] ACC_OFS_DATA_LO  = 6'h03;
  localparam logic [5:0] ACC_OFS_THR_HI   = 6'h04;
  localparam logic [5:0] ACC_OFS_THR_LO   = 6'h05;
  localparam logic [5:0] ACC_OFS_WORD_HI  = 6'h06;
  localparam logic [5:0] ACC_OFS_WORD_LO  = 6'h07;
  localparam logic [5:0] ACC_OFS_TRIM     = 6'h20;
  localparam int         ACC_TRIM_BYTES   = 30;
  localparam int         ACC_TRIM_PER_MODE = 3;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ACC_C0_START   = 7;
  localparam int ACC_C0_VREF_LO = 6;
  localparam int ACC_C0_VPIN    = 5;
  localparam int ACC_C0_REPEAT  = 4;
  localparam int ACC_C1_VREF_HI = 7;
  localparam int ACC_C1_UP_EN   = 6;
  localparam int ACC_C1_LO_EN   = 5;
  localparam int ACC_C1_UP_FLG  = 4;
  localparam int ACC_C1_LO_FLG  = 3;

  // ----------------------------------------------------------------
  // Reset values and decode codes
  // ----------------------------------------------------------------
  localparam logic [7:0] ACC_CTL0_RST   = 8'h00;
  localparam logic [7:0] ACC_CTL1_RST   = 8'h80;
  localparam logic [7:0] ACC_THR_HI_RST = 8'hff;
  localparam logic [7:0] ACC_THR_LO_RST = 8'h00;
  localparam logic [3:0] ACC_SEL_OFFSET_TRIM_VALUE = 4'he;
  localparam logic [3:0] ACC_SEL_TEMP   = 4'hf;
  localparam logic [1:0] ACC_VREF_EXT   = 2'h0;
  localparam logic [1:0] ACC_VREF_1V0   = 2'h1;
  localparam logic [1:0] ACC_VREF_2V0   = 2'h2;

  // ----------------------------------------------------------------
  // Cycle counts
  // ----------------------------------------------------------------
  localparam int ACC_FIRST_CYCLES = 5129;
  localparam int ACC_PWRUP_CYCLES = 40;
  localparam int ACC_REPEAT_CYCLES = 256;
  localparam int ACC_IDLE_CYCLES  = 160;
  localparam int ACC_CNT_W        = 15;

  typedef enum logic [3:0] {
    ACC_ST_IDLE  = 4'b0001,
    ACC_ST_PWRUP = 4'b0010,
    ACC_ST_FIRST = 4'b0100,
    ACC_ST_REPT  = 4'b1000
  } acc_state_t;

endpackage : acc_pkg

// ---- acc_alarm_cmp.sv ----
// Threshold comparison of one converted sample against the two alarm limits
`timescale 1ns/10ps
module acc_alarm_cmp (
  input  wire logic [12:0] i_sample,
  input  wire logic [7:0]  i_upper_threshold,
  input  wire logic [7:0]  i_lower_threshold,
  output logic             o_upper_hit,
  output logic             o_lower_hit
);
  logic       neg;
  logic [7:0] mag;

  // Sign excluded: top eight data bits only
  assign neg = i_sample[12];
  assign mag = i_sample[11:4];

  always_comb begin
    o_upper_hit = !neg && (mag > i_upper_threshold);
    o_lower_hit = neg || (mag < i_lower_threshold);
  end
endmodule : acc_alarm_cmp

// ---- acc_conv_ctrl.sv ----
// Converter sequencing, result registers, alarm flags and interrupt request
//
// Summary of operation
// - First conversion ends 5129 cycles after start, plus 40 if powered down.
// - Start bit clears at first completion and stays zero afterwards.
// - First continuous completion raises an interrupt request.
// - Afterwards a new result every 256 cycles overwrites the data registers.
// - 13-bit result: upper eight bits in data-high, lower five in data-low [7:3].
// - Completion interrupt only while both alarm enables are clear.
// - Sample above upper threshold sets upper flag; interrupts if enabled.
// - Sample below lower threshold sets lower flag; interrupts if enabled.
// - Unsigned thresholds compare with data-high [6:0] and data-low bit 7.
// - Negative samples never hit the upper alarm, always hit the lower.
// - Alarm flags update every conversion; enables only gate the interrupt.
// - Disabled converter raises no interrupt; a pending one stays pending.
// - All three sources share one interrupt line; software reads status.
// - Only hardware sets alarm flags; writing 1 clears, 0 leaves them.
// - Offset calibration input select shorts the differential inputs.
// - Thirty calibration bytes, three per input mode: offset then gain pair.
// - Output word: sign bit 15, data 14..3, unused 2..1, overflow bit 0.
// - Reference select: 00 external, 01 1.0 V, 10 2.0 V, 11 reserved.
// - Writing start during a conversion restarts it from the beginning.
// - Temperature sensor input doubles both first and repeat intervals.
// - 160 idle cycles power the converter down; next request powers up.
//
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/10ps
module acc_conv_ctrl #(
  parameter int              FIRST_CYCLES = acc_pkg::ACC_FIRST_CYCLES,
  parameter logic [239:0]    TRIM_INIT    = '0
) (
  input  wire logic          i_sys_clk,
  input  wire logic          i_nrst,
  input  wire logic          i_ce,
  input  wire logic [5:0]    i_addr,
  input  wire logic [7:0]    i_wdata,
  input  wire logic          i_wr,
  input  wire logic          i_rd,
  output logic      [7:0]    o_rdata,
  input  wire logic [12:0]   i_smp_data,
  input  wire logic          i_smp_ovf,
  output logic               o_mod_run,
  output logic               o_mod_pwr,
  output logic      [3:0]    o_input_select,
  output logic      [2:0]    o_input_stage_sel,
  output logic               o_input_short,
  output logic               o_vref_int_en,
  output logic               o_vref_2v0,
  output logic               o_vref_pin_drive,
  output logic      [15:0]   o_out_word,
  output logic               o_out_valid,
  output logic               o_irq
);
  import acc_pkg::*;

  // ----------------------------------------------------------------
  // Derived counts
  // ----------------------------------------------------------------
  localparam logic [ACC_CNT_W-1:0] FIRST_LEN  = ACC_CNT_W'(FIRST_CYCLES);
  localparam logic [ACC_CNT_W-1:0] REPT_LEN   = ACC_CNT_W'(ACC_REPEAT_CYCLES);
  localparam logic [ACC_CNT_W-1:0] PWRUP_LEN  = ACC_CNT_W'(ACC_PWRUP_CYCLES);
  localparam logic [7:0]           IDLE_LEN   = 8'(ACC_IDLE_CYCLES);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    acc_state_t               st;
    logic [ACC_CNT_W-1:0]     cnt;
    logic [7:0]               idle_cnt;
    logic                     pwr_dn;
    logic                     conv_start_bit;
    logic                     vref_level_lo_bit;
    logic                     vref_pin_drive;
    logic                     repeat_mode_sel;
    logic [3:0]               input_select;
    logic                     vref_level_hi_bit;
    logic                     upper_alarm_en;
    logic                     lower_alarm_en;
    logic                     upper_flag;
    logic                     lower_flag;
    logic [2:0]               input_stage_sel;
    logic [7:0]               upper_threshold;
    logic [7:0]               lower_threshold;
    logic [7:0]               sample_high_byte;
    logic [7:0]               sample_low_byte;
    logic                     ovf;
    logic [ACC_TRIM_BYTES-1:0][7:0] trim;
    logic [7:0]               rdata;
    logic                     irq;
    logic                     out_valid;
    logic                     mod_run;
    logic                     mod_pwr;
    logic                     input_short;
    logic                     vref_int_en;
    logic                     vref_2v0;
    logic                     vref_pin_out;
  } acc_regs_t;

  acc_regs_t s_r;
  acc_regs_t s_nxt;

  logic upper_hit;
  logic lower_hit;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic trim_hit(input logic [5:0] addr);
    trim_hit = (addr >= ACC_OFS_TRIM) && (addr < ACC_OFS_TRIM + 6'(ACC_TRIM_BYTES));
  endfunction : trim_hit

  function automatic logic [4:0] trim_idx(input logic [5:0] addr);
    logic [5:0] d;
    d = addr - ACC_OFS_TRIM;
    trim_idx = d[4:0];
  endfunction : trim_idx

  // Temperature sensor runs at half rate
  function automatic logic [ACC_CNT_W-1:0] scaled(input logic [ACC_CNT_W-1:0] len,
                                                  input logic [3:0] sel);
    scaled = (sel == ACC_SEL_TEMP) ? ACC_CNT_W'({len, 1'b0}) : len;
  endfunction : scaled

  acc_alarm_cmp u_alarm (
    .i_sample          (i_smp_data),
    .i_upper_threshold (s_r.upper_threshold),
    .i_lower_threshold (s_r.lower_threshold),
    .o_upper_hit       (upper_hit),
    .o_lower_hit       (lower_hit)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic       wr_c0;
    logic       wr_c1;
    logic       start_req;
    logic       done;
    logic       clr_up;
    logic       clr_lo;
    logic       set_up;
    logic       set_lo;
    logic [1:0] vsel;
    wr_c0     = 1'b0;
    wr_c1     = 1'b0;
    start_req = 1'b0;
    done      = 1'b0;
    clr_up    = 1'b0;
    clr_lo    = 1'b0;
    set_up    = 1'b0;
    set_lo    = 1'b0;
    vsel      = 2'h0;
    s_nxt     = s_r;
    s_nxt.irq       = 1'b0;
    s_nxt.out_valid = 1'b0;
    s_nxt.rdata     = 8'h00;

    // Register writes
    wr_c0 = i_wr && (i_addr == ACC_OFS_CTL0);
    wr_c1 = i_wr && (i_addr == ACC_OFS_CTL1);
    if (wr_c0) begin
      s_nxt.vref_level_lo_bit = i_wdata[ACC_C0_VREF_LO];
      s_nxt.vref_pin_drive    = i_wdata[ACC_C0_VPIN];
      s_nxt.repeat_mode_sel   = i_wdata[ACC_C0_REPEAT];
      s_nxt.input_select      = i_wdata[3:0];
      start_req               = i_wdata[ACC_C0_START];
    end
    if (wr_c1) begin
      s_nxt.vref_level_hi_bit = i_wdata[ACC_C1_VREF_HI];
      s_nxt.upper_alarm_en    = i_wdata[ACC_C1_UP_EN];
      s_nxt.lower_alarm_en    = i_wdata[ACC_C1_LO_EN];
      s_nxt.input_stage_sel   = i_wdata[2:0];
      clr_up                  = i_wdata[ACC_C1_UP_FLG];
      clr_lo                  = i_wdata[ACC_C1_LO_FLG];
    end
    if (i_wr && (i_addr == ACC_OFS_THR_HI)) begin
      s_nxt.upper_threshold = i_wdata;
    end
    if (i_wr && (i_addr == ACC_OFS_THR_LO)) begin
      s_nxt.lower_threshold = i_wdata;
    end
    // Option space kept writable so trim bytes can be loaded after reset
    if (i_wr && trim_hit(i_addr)) begin
      s_nxt.trim[trim_idx(i_addr)] = i_wdata;
    end

    // Sequencer
    if (s_r.cnt != '0) begin
      s_nxt.cnt = s_r.cnt - ACC_CNT_W'(1);
    end
    case (s_r.st)
      ACC_ST_IDLE: begin
        if (s_r.idle_cnt == IDLE_LEN - 8'(1)) begin
          s_nxt.pwr_dn = 1'b1;
        end else if (!s_r.pwr_dn) begin
          s_nxt.idle_cnt = s_r.idle_cnt + 8'(1);
        end
      end
      ACC_ST_PWRUP: begin
        if (s_r.cnt == ACC_CNT_W'(1)) begin
          s_nxt.pwr_dn = 1'b0;
          s_nxt.st     = ACC_ST_FIRST;
          s_nxt.cnt    = scaled(FIRST_LEN, s_r.input_select);
        end
      end
      ACC_ST_FIRST: begin
        if (s_r.cnt == ACC_CNT_W'(1)) begin
          done                 = 1'b1;
          s_nxt.conv_start_bit = 1'b0;
          if (s_r.repeat_mode_sel) begin
            s_nxt.st  = ACC_ST_REPT;
            s_nxt.cnt = scaled(REPT_LEN, s_r.input_select);
          end else begin
            s_nxt.st = ACC_ST_IDLE;
          end
        end
      end
      ACC_ST_REPT: begin
        if (!s_r.repeat_mode_sel) begin
          s_nxt.st  = ACC_ST_IDLE;
          s_nxt.cnt = '0;
        end else if (s_r.cnt == ACC_CNT_W'(1)) begin
          done      = 1'b1;
          s_nxt.cnt = scaled(REPT_LEN, s_r.input_select);
        end
      end
      default: begin
        s_nxt.st  = ACC_ST_IDLE;
        s_nxt.cnt = '0;
      end
    endcase

    // Start or restart overrides the next state, and the count except during powerup; a completion in the same cycle still stores its result and pulses
    if (start_req) begin
      s_nxt.conv_start_bit = 1'b1;
      s_nxt.idle_cnt       = 8'h00;
      if (s_r.st == ACC_ST_IDLE && s_r.pwr_dn) begin
        s_nxt.st  = ACC_ST_PWRUP;
        s_nxt.cnt = PWRUP_LEN;
      end else if (s_r.st == ACC_ST_PWRUP) begin
        s_nxt.st = ACC_ST_PWRUP;
      end else begin
        s_nxt.st  = ACC_ST_FIRST;
        s_nxt.cnt = scaled(FIRST_LEN, i_wdata[3:0]);
      end
    end
    if (s_nxt.st != ACC_ST_IDLE) begin
      s_nxt.idle_cnt = 8'h00;
    end

    // Completion: raw sample stored, no correction applied
    if (done) begin
      s_nxt.sample_high_byte = i_smp_data[12:5];
      s_nxt.sample_low_byte  = {i_smp_data[4:0], 3'h0};
      s_nxt.ovf              = i_smp_ovf;
      s_nxt.out_valid        = 1'b1;
      set_up                 = upper_hit;
      set_lo                 = lower_hit;
      // Sources only fire on completion, which needs an active converter
      s_nxt.irq = (!s_r.upper_alarm_en && !s_r.lower_alarm_en)
                  || (s_r.upper_alarm_en && upper_hit)
                  || (s_r.lower_alarm_en && lower_hit);
    end
    // Set wins over a clear in the same cycle
    s_nxt.upper_flag = (s_r.upper_flag && !clr_up) || set_up;
    s_nxt.lower_flag = (s_r.lower_flag && !clr_lo) || set_lo;

    // Read data, one cycle after the strobe
    if (i_rd) begin
      case (i_addr)
        ACC_OFS_CTL0:    s_nxt.rdata = {s_r.conv_start_bit, s_r.vref_level_lo_bit, s_r.vref_pin_drive,
                                        s_r.repeat_mode_sel, s_r.input_select};
        ACC_OFS_CTL1:    s_nxt.rdata = {s_r.vref_level_hi_bit, s_r.upper_alarm_en, s_r.lower_alarm_en,
                                        s_r.upper_flag, s_r.lower_flag, s_r.input_stage_sel};
        ACC_OFS_DATA_HI: s_nxt.rdata = s_r.sample_high_byte;
        ACC_OFS_DATA_LO: s_nxt.rdata = s_r.sample_low_byte;
        ACC_OFS_THR_HI:  s_nxt.rdata = s_r.upper_threshold;
        ACC_OFS_THR_LO:  s_nxt.rdata = s_r.lower_threshold;
        ACC_OFS_WORD_HI: s_nxt.rdata = s_r.sample_high_byte;
        ACC_OFS_WORD_LO: s_nxt.rdata = {s_r.sample_low_byte[7:3], 2'h0, s_r.ovf};
        default: begin
          if (trim_hit(i_addr)) begin
            s_nxt.rdata = s_r.trim[trim_idx(i_addr)];
          end else begin
            s_nxt.rdata = 8'h00;
          end
        end
      endcase
    end

    // Analog controls
    vsel                = {s_nxt.vref_level_hi_bit, s_nxt.vref_level_lo_bit};
    s_nxt.vref_int_en   = (vsel == ACC_VREF_1V0) || (vsel == ACC_VREF_2V0);
    s_nxt.vref_2v0      = (vsel == ACC_VREF_2V0);
    // Pin only ever carries an enabled internal reference, never a reserved code
    s_nxt.vref_pin_out  = s_nxt.vref_pin_drive && s_nxt.vref_int_en;
    s_nxt.input_short   = (s_nxt.input_select == ACC_SEL_OFFSET_TRIM_VALUE);
    s_nxt.mod_run       = (s_nxt.st == ACC_ST_FIRST) || (s_nxt.st == ACC_ST_REPT);
    s_nxt.mod_pwr       = !s_nxt.pwr_dn || (s_nxt.st == ACC_ST_PWRUP);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_r                   <= '0;
      s_r.st                <= ACC_ST_IDLE;
      s_r.pwr_dn            <= 1'b1;
      s_r.conv_start_bit    <= ACC_CTL0_RST[ACC_C0_START];
      s_r.vref_level_lo_bit <= ACC_CTL0_RST[ACC_C0_VREF_LO];
      s_r.vref_level_hi_bit <= ACC_CTL1_RST[ACC_C1_VREF_HI];
      s_r.upper_threshold   <= ACC_THR_HI_RST;
      s_r.lower_threshold   <= ACC_THR_LO_RST;
      s_r.trim              <= TRIM_INIT;
      s_r.vref_int_en       <= 1'b1;
      s_r.vref_2v0          <= 1'b1;
    end else if (i_ce) begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_rdata           = s_r.rdata;
  assign o_mod_run         = s_r.mod_run;
  assign o_mod_pwr         = s_r.mod_pwr;
  assign o_input_select    = s_r.input_select;
  assign o_input_stage_sel = s_r.input_stage_sel;
  assign o_input_short     = s_r.input_short;
  assign o_vref_int_en     = s_r.vref_int_en;
  assign o_vref_2v0        = s_r.vref_2v0;
  assign o_vref_pin_drive  = s_r.vref_pin_out;
  assign o_out_word        = {s_r.sample_high_byte, s_r.sample_low_byte[7:3], 2'h0, s_r.ovf};
  assign o_out_valid       = s_r.out_valid;
  assign o_irq             = s_r.irq;

endmodule : acc_conv_ctrl

// ---- acc_filter_model.sv ----
// Behavioural stand-in for the modulator and decimation filter
`timescale 1ns/10ps
module acc_filter_model (
  input  wire logic        i_sys_clk,
  input  wire logic        i_run,
  input  wire logic [12:0] i_value,
  input  wire logic        i_ovf,
  output logic      [12:0] o_smp_data,
  output logic             o_smp_ovf
);
  logic [12:0] churn = 13'h0;

  // Idle output churns so no stale sample can pass for a fresh one
  always @(posedge i_sys_clk) begin
    churn <= churn + 13'h0a53;
  end

  assign o_smp_data = i_run ? i_value : churn;
  assign o_smp_ovf  = i_run ? i_ovf : churn[0];
endmodule : acc_filter_model

// ---- acc_conv_ctrl_properties.sv ----
// Port checker for the converter control block
`timescale 1ns/10ps
module acc_conv_ctrl_chk #(
  parameter int FIRST_CYCLES = 20
) (
  input wire logic        i_sys_clk,
  input wire logic        i_nrst,
  input wire logic        i_ce,
  input wire logic [5:0]  i_addr,
  input wire logic [7:0]  i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [7:0]  o_rdata,
  input wire logic        o_mod_run,
  input wire logic        o_mod_pwr,
  input wire logic [3:0]  o_input_select,
  input wire logic        o_input_short,
  input wire logic        o_vref_int_en,
  input wire logic        o_vref_pin_drive,
  input wire logic [15:0] o_out_word,
  input wire logic        o_out_valid,
  input wire logic        o_irq
);
  logic [7:0]  thr_h, thr_l;
  logic        up_en, lo_en, pend, wr_ok, hi_hit, lo_hit;
  logic [15:0] since, exp_lat;

  // Shadows of software writes predict the alarm outcome
  assign wr_ok  = i_ce && i_wr;
  assign hi_hit = !o_out_word[15] && o_out_word[14:7] > thr_h;
  assign lo_hit = o_out_word[15] || o_out_word[14:7] < thr_l;

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      thr_h          <= 8'hff;
      thr_l          <= 8'h00;
      {up_en, lo_en} <= 2'h0;
      pend           <= 1'b0;
      since          <= 16'h0;
      exp_lat        <= 16'h0;
    end else begin
      if (since != 16'hffff) since <= since + 16'h1;
      if (o_out_valid) pend <= 1'b0;
      if (wr_ok && i_addr == 6'h01) {up_en, lo_en} <= i_wdata[6:5];
      if (wr_ok && i_addr == 6'h04) thr_h <= i_wdata;
      if (wr_ok && i_addr == 6'h05) thr_l <= i_wdata;
      // A start during powerup is ignored, so the old deadline stands
      if (wr_ok && i_addr == 6'h00 && i_wdata[7] && !(pend && !o_out_valid && o_mod_pwr && !o_mod_run)) begin
        pend    <= 1'b1;
        since   <= 16'h0;
        exp_lat <= 16'((i_wdata[3:0] == 4'hf ? 2 : 1) * FIRST_CYCLES + (o_mod_pwr ? 0 : 40));
      end
    end
  end

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_nrst);

  a_rd_quiet: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside answer cycle");
  a_word_gap: assert property (o_out_word[2:1] == 2'b00)
    else $error("unused word bits set");
  a_short_sel: assert property (o_input_short == (o_input_select == 4'he))
    else $error("input short disagrees with select");
  a_vref_pin: assert property (o_vref_pin_drive |-> o_vref_int_en)
    else $error("pin driven without internal reference");
  a_irq_pulse: assert property (o_irq |-> o_out_valid ##1 !o_irq)
    else $error("irq without completion or too long");
  a_done_irq: assert property (o_out_valid && !up_en && !lo_en |-> o_irq)
    else $error("completion irq missing");
  a_alarm_irq: assert property (o_out_valid && (up_en || lo_en) |-> o_irq == (up_en && hi_hit || lo_en && lo_hit))
    else $error("alarm irq wrong");
  a_first_lat: assert property (o_out_valid && pend |-> since == exp_lat)
    else $error("first result at wrong cycle");
  a_lat_bound: assert property (pend |-> since <= exp_lat)
    else $error("first result late");
  a_rep_gap: assert property (o_out_valid && o_mod_run && o_input_select != 4'hf |-> ##256 (o_out_valid || !o_mod_run))
    else $error("repeat result not after 256 cycles");

  c_alarm: cover property (o_irq && (up_en || lo_en));
  c_repeat: cover property (o_out_valid && !pend && o_mod_run);
  c_pwrup: cover property (wr_ok && i_addr == 6'h00 && i_wdata[7] && !o_mod_pwr);
endmodule : acc_conv_ctrl_chk

bind acc_conv_ctrl acc_conv_ctrl_chk #(.FIRST_CYCLES(FIRST_CYCLES)) chk_u (
  .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .o_mod_run(o_mod_run), .o_mod_pwr(o_mod_pwr), .o_input_select(o_input_select),
  .o_input_short(o_input_short), .o_vref_int_en(o_vref_int_en), .o_vref_pin_drive(o_vref_pin_drive),
  .o_out_word(o_out_word), .o_out_valid(o_out_valid), .o_irq(o_irq)
);

// ---- test_adc_conversion_alarm_control.sv ----
// Self-checking bench for the converter control block
`timescale 1ns/10ps
module test_adc_conversion_alarm_control;
  localparam int         FC = 20;
  localparam logic [1:0] EN [8] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h1, 2'h1, 2'h1, 2'h2};
  localparam logic [8:0] SM [8] = '{9'h050, 9'h050, 9'h050, 9'h150, 9'h150, 9'h008, 9'h010, 9'h040};
  localparam logic [1:0] FL [8] = '{2'h2, 2'h2, 2'h2, 2'h1, 2'h1, 2'h1, 2'h0, 2'h0};
  localparam logic [7:0] IQ = 8'h35;

  logic        i_sys_clk, i_nrst, i_wr, i_rd, ovf, smp_ovf, o_mod_run, o_mod_pwr, o_input_short, ce;
  logic        o_vref_int_en, o_vref_2v0, o_vref_pin_drive, o_out_valid, o_irq;
  logic [5:0]  i_addr;
  logic [7:0]  i_wdata, o_rdata;
  logic [12:0] val, smp;
  logic [3:0]  o_input_select;
  logic [2:0]  o_input_stage_sel;
  logic [15:0] o_out_word;
  int          bad_count, compares, cyc, n;

  acc_conv_ctrl #(.FIRST_CYCLES(FC)) dut_u (
    .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_ce(ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_smp_data(smp), .i_smp_ovf(smp_ovf), .o_mod_run(o_mod_run),
    .o_mod_pwr(o_mod_pwr), .o_input_select(o_input_select), .o_input_stage_sel(o_input_stage_sel),
    .o_input_short(o_input_short),
    .o_vref_int_en(o_vref_int_en), .o_vref_2v0(o_vref_2v0), .o_vref_pin_drive(o_vref_pin_drive),
    .o_out_word(o_out_word), .o_out_valid(o_out_valid), .o_irq(o_irq)
  );
  acc_filter_model fm_u (
    .i_sys_clk(i_sys_clk), .i_run(o_mod_run), .i_value(val), .i_ovf(ovf), .o_smp_data(smp), .o_smp_ovf(smp_ovf)
  );

  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  // Hang guard, about four and a half times the expected run
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      $display("[ERR] run time limit expected 0 seen %0d", cyc);
      bad_count++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [7:0] e, input string nm);
    @(posedge i_sys_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd   <= 1'b0;
    #1;
    chk(nm, {8'h00, e}, {8'h00, o_rdata});
  endtask : rd

  // Cycles until the next result pulse, 600 when none comes
  task automatic wv(output int c);
    c = 0;
    do begin
      @(posedge i_sys_clk);
      #1;
      c++;
    end while (o_out_valid !== 1'b1 && c < 600);
  endtask : wv

  task automatic conv(input logic [7:0] d, input int e, input string nm);
    wr(6'h00, d);
    wv(n);
    chk(nm, 16'(e), 16'(n));
  endtask : conv

  task automatic end_sim;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim

  initial begin
    {i_nrst, i_wr, i_rd, i_addr, i_wdata, bad_count, compares, cyc} = '0;
    ce  = 1'b1;
    val = 13'h0aa5;
    ovf = 1'b1;
    repeat (3) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    rd(6'h00, 8'h00, "ctl0");
    rd(6'h01, 8'h80, "ctl1");
    rd(6'h04, 8'hff, "thr_hi");
    wr(6'h04, 8'h40);
    wr(6'h05, 8'h10);
    wr(6'h10, 8'h5a);
    rd(6'h04, 8'h40, "thr_hi");
    rd(6'h05, 8'h10, "thr_lo");
    rd(6'h10, 8'h00, "unmapped");
    wr(6'h21, 8'h3c);
    rd(6'h21, 8'h3c, "trim");
    // Let the read answer clear before freezing
    @(posedge i_sys_clk);
    ce <= 1'b0;
    wr(6'h04, 8'h22);
    ce <= 1'b1;
    rd(6'h04, 8'h40, "ce_freeze");
    $display("register test done");
    conv(8'h90, FC + 40, "first_latency");
    chk("irq", 16'h1, {15'h0, o_irq});
    chk("word", {13'h0aa5, 3'b001}, o_out_word);
    val = 13'h1234;
    ovf = 1'b0;
    wv(n);
    chk("interval", 16'd256, 16'(n));
    rd(6'h02, val[12:5], "data_hi");
    rd(6'h03, {val[4:0], 3'b000}, "data_lo");
    rd(6'h00, 8'h10, "start_bit");
    $display("continuous test done");
    for (int k = 0; k < 8; k++) begin
      wr(6'h01, {1'b1, EN[k], 5'b11000});
      val = {SM[k], 4'h5};
      wv(n);
      chk("alarm_irq", {15'h0, IQ[k]}, {15'h0, o_irq});
      rd(6'h01, {1'b1, EN[k], FL[k], 3'b000}, "alarm_flags");
    end
    val = 13'h1f05;
    wv(n);
    wr(6'h01, 8'h83);
    rd(6'h01, 8'h8b, "flag_keep");
    chk("stage_sel", 16'h3, {13'h0, o_input_stage_sel});
    wr(6'h01, 8'h88);
    rd(6'h01, 8'h80, "flag_clear");
    $display("alarm test done");
    wr(6'h00, 8'h00);
    repeat (260) @(posedge i_sys_clk);
    #1;
    chk("pwr_down", 16'h0, {15'h0, o_mod_pwr});
    wr(6'h00, 8'h9e);
    repeat (50) @(posedge i_sys_clk);
    conv(8'h9e, FC, "restart");
    chk("short", 16'h1, {15'h0, o_input_short});
    wr(6'h00, 8'h0e);
    repeat (150) @(posedge i_sys_clk);
    #1;
    chk("pwr_kept", 16'h1, {15'h0, o_mod_pwr});
    wv(n);
    chk("stopped", 16'd600, 16'(n));
    chk("pwr_down", 16'h0, {15'h0, o_mod_pwr});
    conv(8'h9f, 2 * FC + 40, "temp_first");
    wv(n);
    chk("temp_interval", 16'd512, 16'(n));
    wr(6'h00, 8'h0f);
    $display("sequencing test done");
    for (int k = 0; k < 4; k++) begin
      wr(6'h01, {k[1], 7'h00});
      wr(6'h00, {1'b0, k[0], 1'b1, 5'h00});
      repeat (2) @(posedge i_sys_clk);
      #1;
      chk("vref_int", {15'h0, k[1] ^ k[0]}, {15'h0, o_vref_int_en});
      chk("vref_2v0", {15'h0, k[1] & ~k[0]}, {15'h0, o_vref_2v0});
      chk("vref_pin", {15'h0, k[1] ^ k[0]}, {15'h0, o_vref_pin_drive});
    end
    $display("reference test done");
    end_sim();
  end
endmodule : test_adc_conversion_alarm_control
